// File: common/power_settings_pkg.sv
// shared constants for the power result and host settings register bank
package power_settings_pkg;
	localparam int unsigned num_channels = 4;
	localparam logic [7:0] power_base_addr = 8'h17;
	localparam logic [7:0] settings_addr = 8'h1c;
	localparam logic [7:0] unmapped_read_value = 8'hff;
	localparam int unsigned bus_voltage_width = 16;
	localparam int unsigned sense_voltage_width = 16;
	localparam int unsigned bus_voltage_msbs = 14;
	localparam int unsigned power_field_width = 30;
	localparam int unsigned power_field_lsb = 2;
	localparam int unsigned second_level_bit = 7;
	localparam int unsigned first_level_bit = 6;
	localparam int unsigned any_alert_bit = 5;
	localparam int unsigned reset_flag_bit = 4;
	localparam int unsigned timeout_en_bit = 3;
	localparam int unsigned byte_count_bit = 2;
	localparam int unsigned no_skip_bit = 1;
	localparam int unsigned hispeed_bit = 0;
	localparam logic [7:0] settings_reset = 8'h10;
endpackage

// File: verilog/power_product.sv
// per-channel product of bus and sense voltage in the reported 30-bit form
`timescale 1ns/1ps
module power_product #(
	parameter int unsigned bus_width = power_settings_pkg::bus_voltage_width,
	parameter int unsigned sense_width = power_settings_pkg::sense_voltage_width
) (
	// operands
	input wire logic [bus_width-1:0] bus_voltage,
	input wire logic [sense_width-1:0] sense_voltage,
	input wire logic bus_bipolar,
	input wire logic sense_bipolar,
	// result, power field in bits 31:2
	output logic [31:0] power_word
);
	localparam int unsigned msbs = power_settings_pkg::bus_voltage_msbs;
	localparam int unsigned pw = power_settings_pkg::power_field_width;
	logic signed [msbs:0] bus_op;
	logic signed [sense_width:0] sense_op;
	logic signed [msbs+sense_width+1:0] full;
	logic [pw-1:0] field;
	// operands always treated as signed; unipolar codes get a zero extension
	always_comb begin
		bus_op = signed'({bus_bipolar & bus_voltage[bus_width-1],
			bus_voltage[bus_width-1 -: msbs]});
		sense_op = signed'({sense_bipolar & sense_voltage[sense_width-1], sense_voltage});
		full = bus_op * sense_op;
		// full precision kept until this single truncation to the field
		if (bus_bipolar || sense_bipolar) begin
			field = {full[msbs+sense_width+1], full[msbs+sense_width-2 -: pw-1]};
		end else begin
			field = full[msbs+sense_width-1 -: pw];
		end
		power_word = {field, 2'b00};
	end
endmodule

// File: verilog/power_result_and_bus_settings.sv
// power result registers and host interface settings register
// Function
// - power is 14 bus msbs times sense, 30-bit field in bits 31:2
// - bipolar on either input gives 29 bits plus sign result
// - power register bits 1:0 read zero on enabled channels
// - accumulators receive the same power values as the result registers
// - math uses signed operands; both unipolar reports unsigned
// - internal product keeps more precision than reported voltages
// - settings bits readable, all but bits 5 and 4 writable anytime (bit 4 clear only), effective at once
// - bit 7 drives second pin level when gpio: 0 low, 1 released
// - bit 6 drives first pin level when gpio: 0 low, 1 released
// - bit 5 set by any enabled alert except conversion complete
// - alert summary clears when causing alert clears, not by host
// - bit 4 forced to one only by internal power-on reset
// - host clears reset flag then polls; one means reset since
// - bit 3 enables smbus timeout, zero after reset
// - bit 1 selects no-skip auto increment; disabled channels read ff
`timescale 1ns/1ps
module power_result_and_bus_settings #(
	parameter int unsigned channels = power_settings_pkg::num_channels
) (
	// clock and reset (reset is the internal power-on or powerdown reset)
	input wire logic ref_clk,
	input wire logic arst_n,
	// register port from the two-wire interface engine
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [1:0] reg_byte_sel,
	output logic [7:0] reg_rdata,
	// measurement inputs, one conversion strobe updates all channels
	input wire logic conv_done,
	input wire logic [channels*16-1:0] bus_voltage,
	input wire logic [channels*16-1:0] sense_voltage,
	input wire logic [channels-1:0] bus_bipolar,
	input wire logic [channels-1:0] sense_bipolar,
	input wire logic [channels-1:0] channel_active,
	// alert sources, conversion complete excluded by the source
	input wire logic alert_active,
	// pin function selection
	input wire logic first_pin_is_alert,
	input wire logic second_pin_is_alert,
	input wire logic first_alert_drive,
	input wire logic second_alert_drive,
	// pins, open drain: output enable low means driving low
	output logic first_multi_function_pin_oe_n,
	output logic second_multi_function_pin_oe_n,
	// settings to other blocks
	output logic smbus_timeout_en,
	output logic byte_count_en,
	output logic no_skip,
	output logic high_speed_filter_select,
	// accumulator feed
	output logic acc_valid,
	output logic [channels*32-1:0] acc_power
);
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [7:0] settings_r;
	logic [7:0] settings_nxt;
	logic [31:0] power_r [channels];
	logic [31:0] power_nxt [channels];
	logic [7:0] rdata_nxt;
	localparam int unsigned por_bit = power_settings_pkg::reset_flag_bit;

	// one comparator shape for every register decode
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction

	// alert mode overrides the stored level; the level bit itself stays r/w
	function automatic logic pin_release(input logic is_alert, input logic alert_drive,
		input logic level);
		logic rel;
		rel = level;
		if (is_alert) begin
			rel = ~alert_drive;
		end
		return rel;
	endfunction

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	for (genvar c = 0; c < channels; c++) begin : g_ch
		power_product u_prod (
			.bus_voltage(bus_voltage[c*16 +: 16]),
			.sense_voltage(sense_voltage[c*16 +: 16]),
			.bus_bipolar(bus_bipolar[c]),
			.sense_bipolar(sense_bipolar[c]),
			.power_word(power_nxt[c])
		);
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				power_r[c] <= 32'h0000_0000;
			end else if (conv_done) begin
				power_r[c] <= power_nxt[c];
			end
		end
		// accumulator sees exactly the register contents
		assign acc_power[c*32 +: 32] = power_r[c];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_valid <= 1'b0;
		end else begin
			acc_valid <= conv_done;
		end
	end

	// settings: host writes all but the alert summary, which tracks its cause, and the reset flag, which it can only clear
	always_comb begin
		settings_nxt = settings_r;
		if (reg_wr && addr_hit(reg_addr, power_settings_pkg::settings_addr)) begin
			settings_nxt = reg_wdata;
			// the host may only clear the reset flag; nothing but reset sets it
			settings_nxt[por_bit] = settings_r[por_bit] & reg_wdata[por_bit];
		end
		settings_nxt[power_settings_pkg::any_alert_bit] = alert_active;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			settings_r <= power_settings_pkg::settings_reset;
		end else begin
			settings_r <= settings_nxt;
		end
	end

	// oe_n low pulls the pin low; high releases it to the resistor
	// pins stay released in reset so nothing is pulled low before settings load
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_multi_function_pin_oe_n <= 1'b1;
		end else begin
			first_multi_function_pin_oe_n <= pin_release(first_pin_is_alert, first_alert_drive,
				settings_nxt[power_settings_pkg::first_level_bit]);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			second_multi_function_pin_oe_n <= 1'b1;
		end else begin
			second_multi_function_pin_oe_n <= pin_release(second_pin_is_alert, second_alert_drive,
				settings_nxt[power_settings_pkg::second_level_bit]);
		end
	end

	// copies follow the next value so a write acts at its own edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			smbus_timeout_en <= 1'b0;
		end else begin
			smbus_timeout_en <= settings_nxt[power_settings_pkg::timeout_en_bit];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_count_en <= 1'b0;
			no_skip <= 1'b0;
			high_speed_filter_select <= 1'b0;
		end else begin
			byte_count_en <= settings_nxt[power_settings_pkg::byte_count_bit];
			no_skip <= settings_nxt[power_settings_pkg::no_skip_bit];
			high_speed_filter_select <= settings_nxt[power_settings_pkg::hispeed_bit];
		end
	end

	// read mux: power registers give one byte at a time, byte 3 is the msb
	always_comb begin
		rdata_nxt = 8'h00;
		if (addr_hit(reg_addr, power_settings_pkg::settings_addr)) begin
			rdata_nxt = settings_r;
		end
		for (int i = 0; i < channels; i++) begin
			if (addr_hit(reg_addr, power_settings_pkg::power_base_addr + 8'(i))) begin
				if (!channel_active[i]) begin
					rdata_nxt = power_settings_pkg::unmapped_read_value;
				end else begin
					rdata_nxt = power_r[i][{reg_byte_sel, 3'b000} +: 8];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end
	end
endmodule

// File: sim/power_result_and_bus_settings_props.sv
// port assertions for the power result and settings bank
`timescale 1ns/1ps
module power_result_and_bus_settings_props #(parameter int unsigned channels = 4) (
	// register port
	input wire logic ref_clk, arst_n, reg_wr, reg_rd,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire logic [1:0] reg_byte_sel,
	// measurement, pins and settings
	input wire logic conv_done, acc_valid, first_pin_is_alert, first_alert_drive,
	input wire logic first_multi_function_pin_oe_n, second_multi_function_pin_oe_n,
	input wire logic second_pin_is_alert, second_alert_drive, smbus_timeout_en, no_skip,
	input wire logic [channels-1:0] channel_active,
	input wire logic [channels*32-1:0] acc_power
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire logic settings_wr = reg_wr && reg_addr == 8'h1c;
	acc_strobe_a: assert property (acc_valid |-> $past(conv_done))
		else $error("accumulator strobe without conversion");
	acc_hold_a: assert property (!conv_done |=> $stable(acc_power))
		else $error("accumulator feed moved without conversion");
	ctrl_bits_a: assert property (settings_wr |=>
		{smbus_timeout_en, no_skip} == {$past(reg_wdata[3]), $past(reg_wdata[1])})
		else $error("control bits not applied");
	first_level_a: assert property (settings_wr && !first_pin_is_alert |=>
		first_multi_function_pin_oe_n == $past(reg_wdata[6])) else $error("first pin level");
	second_level_a: assert property (settings_wr && !second_pin_is_alert |=>
		second_multi_function_pin_oe_n == $past(reg_wdata[7])) else $error("second pin level");
	alert_mode_a: assert property (first_pin_is_alert |=>
		first_multi_function_pin_oe_n == !$past(first_alert_drive)) else $error("alert drive");
	second_alert_a: assert property (second_pin_is_alert |=>
		second_multi_function_pin_oe_n == !$past(second_alert_drive))
		else $error("second alert drive");
	low_bits_a: assert property (reg_rd && reg_addr == 8'h17 && reg_byte_sel == 2'h0 &&
		channel_active[0] |=> reg_rdata[1:0] == 2'h0) else $error("power low bits set");
	idle_fill_a: assert property (reg_rd && reg_addr == 8'h18 && !channel_active[1] |=>
		reg_rdata == 8'hff) else $error("disabled channel not ff");
	cover property (conv_done ##1 acc_valid);
	cover property (settings_wr);
	cover property (first_pin_is_alert && !first_alert_drive);
	cover property (first_pin_is_alert && first_alert_drive);
endmodule
bind power_result_and_bus_settings power_result_and_bus_settings_props #(.channels(channels)) chk (.*);

// File: sim/host_model.sv
// host controller model on the register port
`timescale 1ns/1ps
module host_model (
	// clock and answer
	input wire logic ref_clk,
	input wire logic [7:0] reg_rdata,
	// requests
	output logic [7:0] reg_addr, reg_wdata,
	output logic reg_wr, reg_rd,
	output logic [1:0] reg_byte_sel
);
	initial {reg_addr, reg_wdata, reg_wr, reg_rd, reg_byte_sel} = '0;
	task automatic xfer(input logic w, input logic [7:0] a, d, input logic [1:0] s,
		output logic [7:0] q);
		@(negedge ref_clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata, reg_byte_sel} = {w, ~w, a, d, s};
		@(negedge ref_clk);
		{reg_wr, reg_rd} = 2'h0;
		// released data must not look still valid
		reg_wdata = ~reg_wdata;
		q = reg_rdata;
	endtask
endmodule

// File: sim/power_result_and_bus_settings_bench.sv
// self-checking bench for the power result and settings bank
`timescale 1ns/1ps
module power_result_and_bus_settings_bench;
	logic ref_clk = 0, arst_n = 0, conv_done = 0, alert_active = 0, first_pin_is_alert = 0;
	logic second_pin_is_alert = 0, first_alert_drive = 0, second_alert_drive = 0;
	logic reg_wr, reg_rd, acc_valid, first_multi_function_pin_oe_n, second_multi_function_pin_oe_n;
	logic smbus_timeout_en, byte_count_en, no_skip, high_speed_filter_select;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
	logic [1:0] reg_byte_sel;
	logic [63:0] bus_voltage = '0, sense_voltage = '0;
	logic [3:0] bus_bipolar = '0, sense_bipolar = '0, channel_active = 4'hd;
	logic [127:0] acc_power;
	logic [31:0] w;
	int mismatches = 0, num_checks = 0;
	power_result_and_bus_settings DUT (.*);
	host_model host (.*);
	initial forever #2 ref_clk = ~ref_clk;
	task chk(input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task rd(input logic [7:0] a, input logic [1:0] s = 2'h0);
		host.xfer(1'b0, a, 8'h00, s, q);
	endtask
	task t_settings;
		rd(8'h1c);
		chk(q, 8'h10);
		chk({first_multi_function_pin_oe_n, second_multi_function_pin_oe_n}, 2'h0);
		chk({smbus_timeout_en, byte_count_en, no_skip, high_speed_filter_select}, 4'h0);
		host.xfer(1'b1, 8'h1c, 8'hcf, 2'h0, q);
		rd(8'h1c);
		chk(q, 8'hcf);
		chk({first_multi_function_pin_oe_n, second_multi_function_pin_oe_n}, 2'h3);
		chk({smbus_timeout_en, byte_count_en, no_skip, high_speed_filter_select}, 4'hf);
		host.xfer(1'b1, 8'h1c, 8'h30, 2'h0, q);
		rd(8'h1c);
		chk(q, 8'h00);
		chk({first_multi_function_pin_oe_n, second_multi_function_pin_oe_n}, 2'h0);
		alert_active = 1;
		rd(8'h1c);
		chk(q, 8'h20);
		alert_active = 0;
		first_pin_is_alert = 1;
		second_pin_is_alert = 1;
		rd(8'h1c);
		chk(q, 8'h00);
		chk({first_multi_function_pin_oe_n, second_multi_function_pin_oe_n}, 2'h3);
		first_alert_drive = 1;
		rd(8'h1c);
		chk({first_multi_function_pin_oe_n, second_multi_function_pin_oe_n}, 2'h1);
		{first_pin_is_alert, second_pin_is_alert, first_alert_drive} = 3'h0;
		$display("settings test done");
	endtask
	task t_power(input logic bb, input logic sb, input logic [15:0] bv, input logic [31:0] e);
		bus_voltage[15:0] = bv;
		sense_voltage[15:0] = 16'hffff;
		bus_bipolar[0] = bb;
		sense_bipolar[0] = sb;
		conv_done = 1;
		@(negedge ref_clk);
		conv_done = 0;
		chk({acc_valid, acc_power[31:0]}, {1'b1, e});
		for (int b = 3; b >= 0; b--) begin
			rd(8'h17, 2'(b));
			w = {w[23:0], q};
		end
		chk(w, e);
		rd(8'h18);
		chk(q, 8'hff);
		$display("power test done");
	endtask
	task t_por;
		arst_n = 0;
		repeat (2) @(negedge ref_clk);
		arst_n = 1;
		repeat (3) @(negedge ref_clk);
		rd(8'h1c);
		chk(q, 8'h10);
		$display("reset test done");
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge ref_clk);
		arst_n = 1;
		repeat (3) @(negedge ref_clk);
		t_settings;
		t_power(1'b0, 1'b0, 16'h0007, 32'h0003_fffc);
		t_power(1'b0, 1'b1, 16'h0007, 32'hffff_fffc);
		t_power(1'b1, 1'b0, 16'hfffc, 32'hfffc_0004);
		t_por;
		report_and_stop;
	end
	initial begin
		#4000;
		mismatches++;
		report_and_stop;
	end
endmodule
